/* File: verilog/fmci_top.sv */
// Command interpreter, baud sequencer and command FIFO of the FSK modem.
`timescale 1ns/10ps
`default_nettype none
`include "fmci_map.svh"

// ----------------------------------------------------------------
// Command FIFO
// ----------------------------------------------------------------
module fmci_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         clk_i,
    input  wire logic         reset_i,
    input  wire logic [W-1:0] in_data_i,
    input  wire logic         in_valid_i,
    output logic              in_ready_o,
    output logic [W-1:0]      out_data_o,
    output logic              out_valid_o,
    input  wire logic         out_ready_i
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;
    logic [AW:0]  next_count;
    logic [AW:0]  count;
    logic         push;
    logic         pop;

    assign push       = in_valid_i && in_ready_o;
    assign pop        = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr[AW-1:0]];

    always_comb
    begin
        next_count = count;
        if (push && !pop)
            next_count = count + (AW+1)'(1);
        else if (pop && !push)
            next_count = count - (AW+1)'(1);
    end

    always_ff @(posedge clk_i)
    begin
        if (push)
            mem[wr_ptr[AW-1:0]] <= in_data_i;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            in_ready_o  <= 1'b0;
            out_valid_o <= 1'b0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + (AW+1)'(1);
            if (pop)
                rd_ptr <= rd_ptr + (AW+1)'(1);
            count       <= next_count;
            // Full and empty are registered so both handshakes stay honest.
            in_ready_o  <= next_count != (AW+1)'(D);
            out_valid_o <= next_count != '0;
        end
    end

    // Writes into a full FIFO would be lost silently.
    a_fifo_no_overrun : assert property (@(posedge clk_i) disable iff (reset_i)
        count == (AW+1)'(D) |-> !in_ready_o)
        else $error("FIFO accepts data while full");

endmodule : fmci_fifo

// ----------------------------------------------------------------
// Top level
// ----------------------------------------------------------------
module fmci_top
    import fmci_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] received_command_word_i,
    input  wire logic       command_valid_i,
    output logic            command_ready_o,
    output logic [7:0]      returned_status_word_o,
    input  wire logic       frame_flag_i,
    input  wire logic [7:0] codec_in_sample_i,
    output logic [7:0]      codec_out_sample_o,
    input  wire logic [7:0] tx_sample_i,
    output logic [7:0]      rx_sample_o,
    output logic            sample_strobe_o,
    input  wire logic       agc_disable_i,
    input  wire logic       inband_energy_detect_i,
    input  wire logic       rx_data_bit_i,
    output logic [1:0]      speed_o,
    output logic            bell_mode_o,
    output logic            call_role_flag_o,
    output logic            loopback_o,
    output logic [1:0]      tx_mode_o,
    output logic [1:0]      tone_sel_o,
    output logic [1:0]      rx_mode_o,
    output logic            fsk_enable_o,
    output logic            tone_dialling_flag_o,
    output logic [3:0]      dtmf_digit_o,
    output logic            command_decode_step_o,
    output logic            gain_control_update_o,
    output logic [4:0]      tx_sample_counter_o
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    fmci_state_t state;
    fmci_state_t next_state;
    fmci_mode_t  mode;
    fmci_cmd_t   cmd;
    fmci_cmd_t   fifo_word;
    logic        fifo_valid;
    logic        fifo_pop;
    logic        frame_s1;
    logic        frame_s2;
    logic        frame_s3;
    logic        frame_rise;
    logic [7:0]  codec_s1;
    logic [7:0]  codec_s2;
    logic [4:0]  cnt;
    logic [8:0]  busy_cnt;
    logic        first_slot;
    logic        last_slot;
    logic        reserved_op;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    assign cnt        = tx_sample_counter_o;
    assign first_slot = cnt == `FMCI_SAMPLES_PER_BAUD;
    assign last_slot  = cnt == `FMCI_CNT_ZERO;
    assign frame_rise = frame_s2 && !frame_s3;
    // The command for a baud is taken only when its first sample arrives.
    assign fifo_pop   = state == ST_XCHG && first_slot && fifo_valid;
    assign mode       = '{speed_o, bell_mode_o, call_role_flag_o,
                          loopback_o, tx_mode_o, tone_sel_o, rx_mode_o,
                          fsk_enable_o};
    assign reserved_op = !(cmd.op inside {`FMCI_OP_PROTO, `FMCI_OP_OPER,
                           `FMCI_OP_DTMF, `FMCI_OP_TXMODE,
                           `FMCI_OP_RXMODE, `FMCI_OP_FSK});

    // ------------------------------------------------------------
    // Command port buffer
    // ------------------------------------------------------------
    // Commands queue here so a controller that runs ahead is held back
    // by command_ready_o rather than overwriting an unread word.
    fmci_fifo #(
        .W (`FMCI_WORD_W),
        .D (`FMCI_FIFO_DEPTH)
    ) u_cmd_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .in_data_i   (received_command_word_i),
        .in_valid_i  (command_valid_i),
        .in_ready_o  (command_ready_o),
        .out_data_o  (fifo_word),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            frame_s1 <= 1'b0;
            frame_s2 <= 1'b0;
            frame_s3 <= 1'b0;
            codec_s1 <= `FMCI_SILENCE;
            codec_s2 <= `FMCI_SILENCE;
        end
        else
        begin
            frame_s1 <= frame_flag_i;
            frame_s2 <= frame_s1;
            frame_s3 <= frame_s2;
            codec_s1 <= codec_in_sample_i;
            codec_s2 <= codec_s1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        case (state)
            ST_WAIT:   next_state = frame_rise ? ST_XCHG : ST_WAIT;
            ST_XCHG:   next_state = fifo_pop ? ST_DECODE : ST_TASK;
            ST_DECODE: next_state = ST_TASK;
            ST_TASK:   next_state = ST_WAIT;
            default:   next_state = ST_WAIT;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            state <= ST_WAIT;
        else
            state <= next_state;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            busy_cnt <= '0;
        else if (state == ST_WAIT)
            busy_cnt <= '0;
        else
            busy_cnt <= busy_cnt + 9'h001;
    end

    // ------------------------------------------------------------
    // Codec sample exchange
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            codec_out_sample_o <= `FMCI_SILENCE;
            rx_sample_o        <= `FMCI_SILENCE;
            sample_strobe_o    <= 1'b0;
        end
        else
        begin
            sample_strobe_o <= state == ST_XCHG;
            if (state == ST_XCHG)
            begin
                // An idle transmitter sends silence, not the modulator.
                codec_out_sample_o <= (tx_mode_o == `FMCI_TX_IDLE) ?
                                      `FMCI_SILENCE : tx_sample_i;
                rx_sample_o        <= codec_s2;
            end
        end
    end

    // ------------------------------------------------------------
    // Baud position counter
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            tx_sample_counter_o <= `FMCI_SAMPLES_PER_BAUD;
        else if (state == ST_TASK)
            tx_sample_counter_o <= last_slot ? `FMCI_SAMPLES_PER_BAUD
                                 : cnt - `FMCI_CNT_STEP;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            command_decode_step_o <= 1'b0;
            gain_control_update_o <= 1'b0;
        end
        else
        begin
            command_decode_step_o <= state == ST_DECODE;
            gain_control_update_o <= state == ST_TASK && last_slot;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            cmd <= '0;
        else if (fifo_pop)
            cmd <= fifo_word;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            speed_o          <= 2'h0;
            bell_mode_o      <= 1'b0;
            call_role_flag_o <= 1'b1;
            loopback_o       <= 1'b0;
            tx_mode_o        <= `FMCI_TX_IDLE;
            tone_sel_o       <= 2'h0;
            rx_mode_o        <= `FMCI_RX_IDLE;
            fsk_enable_o     <= 1'b0;
            dtmf_digit_o     <= 4'h0;
        end
        else if (state == ST_DECODE)
        begin
            // Reserved codes fall through the case and leave every mode.
            case (cmd.op)
                `FMCI_OP_PROTO:
                begin
                    speed_o          <= cmd.arg[1:0];
                    bell_mode_o      <= cmd.arg[2];
                    call_role_flag_o <= !cmd.arg[3];
                end
                `FMCI_OP_OPER:
                begin
                    if (cmd.arg[1:0] == `FMCI_OPER_LINE)
                        loopback_o <= 1'b0;
                    else if (cmd.arg[1:0] == `FMCI_OPER_LOOP)
                        loopback_o <= 1'b1;
                end
                `FMCI_OP_DTMF:
                    dtmf_digit_o <= cmd.arg;
                `FMCI_OP_TXMODE:
                begin
                    if (cmd.arg[1:0] != `FMCI_TX_RSVD)
                        tx_mode_o <= cmd.arg[1:0];
                    if (cmd.arg[3:2] != `FMCI_TONE_RSVD)
                        tone_sel_o <= cmd.arg[3:2];
                end
                `FMCI_OP_RXMODE:
                begin
                    if (cmd.arg[1:0] == `FMCI_RX_IDLE ||
                        cmd.arg[1:0] == `FMCI_RX_DATA)
                        rx_mode_o <= cmd.arg[1:0];
                end
                `FMCI_OP_FSK:
                    fsk_enable_o <= cmd.arg[0];
                default:
                    fsk_enable_o <= fsk_enable_o;
            endcase
        end
    end

    // A digit is dialled for one baud; the flag drops on the last slot,
    // so configuration resumes with the next command.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            tone_dialling_flag_o <= 1'b0;
        else if (state == ST_DECODE && cmd.op == `FMCI_OP_DTMF)
            tone_dialling_flag_o <= 1'b1;
        else if (state == ST_TASK && last_slot)
            tone_dialling_flag_o <= 1'b0;
    end

    // ------------------------------------------------------------
    // Returned status word
    // ------------------------------------------------------------
    // The reset value stands until the first sample has been processed.
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            returned_status_word_o <= `FMCI_STAT_RESET;
        else if (state == ST_TASK)
            returned_status_word_o <= {agc_disable_i,
                                       inband_energy_detect_i,
                                       `FMCI_STAT_RSVD_HI,
                                       rx_data_bit_i,
                                       `FMCI_STAT_RSVD_LO};
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_reset_status_word : assert property (
        $past(reset_i) |-> returned_status_word_o == `FMCI_STAT_RESET)
        else $error("Status word not 81h after reset");

    a_decode_first_slot : assert property (
        command_decode_step_o |-> cnt == `FMCI_SAMPLES_PER_BAUD)
        else $error("Command decoded outside first slot");

    a_gain_last_slot : assert property (
        state == ST_TASK && last_slot |=> gain_control_update_o
        ##1 !gain_control_update_o)
        else $error("Gain update not on last slot");

    a_counter_step : assert property (
        state == ST_TASK && !last_slot
        |=> cnt == $past(cnt) - `FMCI_CNT_STEP)
        else $error("Sample counter did not decrement");

    a_counter_reload : assert property (
        state == ST_TASK && last_slot |=> cnt == `FMCI_SAMPLES_PER_BAUD)
        else $error("Sample counter did not reload to 31");

    a_wait_for_frame : assert property (
        state == ST_WAIT && !frame_rise |=> state == ST_WAIT)
        else $error("Sequencer left wait without frame flag");

    a_sample_budget : assert property (
        busy_cnt < `FMCI_MAX_SAMPLE)
        else $error("Sample processing exceeded budget");

    a_role_follows_cmd : assert property (
        state == ST_DECODE && cmd.op == `FMCI_OP_PROTO
        |=> call_role_flag_o == !$past(cmd.arg[3]))
        else $error("Call role flag wrong after protocol command");

    a_reserved_ignored : assert property (
        state == ST_DECODE && reserved_op |=> $stable(mode))
        else $error("Reserved command changed a mode");

    a_status_reserved : assert property (
        state == ST_TASK |=> returned_status_word_o[2:1] == 2'h3
        && returned_status_word_o[5:4] == 2'h0)
        else $error("Reserved status bits wrong");

    a_dtmf_flag : assert property (
        state == ST_DECODE && cmd.op == `FMCI_OP_DTMF
        |=> tone_dialling_flag_o && dtmf_digit_o == $past(cmd.arg))
        else $error("DTMF command did not start dialling");

    c_dtmf_dialled : cover property (
        state == ST_DECODE && cmd.op == `FMCI_OP_DTMF);
    c_gain_update : cover property (gain_control_update_o);
    c_protocol_cmd : cover property (
        state == ST_DECODE && cmd.op == `FMCI_OP_PROTO);
    c_fifo_full : cover property (!command_ready_o && command_valid_i);

endmodule : fmci_top
`default_nettype wire

/* File: verilog/fmci_map.svh */
// Constant map for the FSK modem command interpreter and baud sequencer.
// What this block does
// - Protocol command bits 1:0 select speed.
// - Protocol command bit 2 picks CCITT or Bell.
// - Protocol command bit 3 picks answer or originate.
// - Operation command selects line or analog loopback.
// - DTMF command dials digit, then returns.
// - Transmit command bits 1:0 select transmitter mode.
// - Transmit command bits 3:2 select answer tone.
// - Receive command bits 1:0 select receiver mode.
// - FSK command bit 0 selects 300 bps.
// - One codec sample per frame, 32 per baud.
// - Sequencer waits for frame flag, one sample.
// - Command decode only on first sample slot.
// - Gain control update only on last slot.
// - Each sample finishes in under 480 cycles.
// - Codec samples are 8-bit companded words.
// - Status bit 7 reports gain control disable.
// - Status bit 6 reports in-band energy.
// - Status bit 3 carries last received bit.
// - Call role flag: zero originate, one answer.
// - Tone dialling flag high while DTMF sent.
// - Transmit sample counter uses 32-sample baud.
// - Counter starts 31, decrements, reloads after zero.
// - Status word reads 81h after reset.
// - Commands and status use coprocessor port.
`ifndef FMCI_MAP_SVH
`define FMCI_MAP_SVH

// ----------------------------------------------------------------
// Command codes in the upper nibble
// ----------------------------------------------------------------
`define FMCI_OP_PROTO     4'hF
`define FMCI_OP_OPER      4'hD
`define FMCI_OP_DTMF      4'h9
`define FMCI_OP_TXMODE    4'h8
`define FMCI_OP_RXMODE    4'h7
`define FMCI_OP_FSK       4'h5

// ----------------------------------------------------------------
// Field codes
// ----------------------------------------------------------------
`define FMCI_OPER_LINE    2'h0
`define FMCI_OPER_LOOP    2'h1
`define FMCI_TX_RSVD      2'h3
`define FMCI_TONE_RSVD    2'h3
`define FMCI_RX_IDLE      2'h0
`define FMCI_RX_DATA      2'h2
`define FMCI_TX_IDLE      2'h0

// ----------------------------------------------------------------
// Status word layout and reset value
// ----------------------------------------------------------------
`define FMCI_STAT_RESET   8'h81
`define FMCI_STAT_RSVD_HI 2'h0
`define FMCI_STAT_RSVD_LO 3'h7

// ----------------------------------------------------------------
// Baud and timing counts
// ----------------------------------------------------------------
`define FMCI_SAMPLES_PER_BAUD         5'h1F
`define FMCI_CNT_ZERO     5'h00
`define FMCI_CNT_STEP     5'h01
`define FMCI_MAX_SAMPLE   9'h1E0
`define FMCI_FIFO_DEPTH   32
`define FMCI_WORD_W       8
`define FMCI_SILENCE      8'h00

`endif

/* File: verilog/fmci_pkg.sv */
// Types shared by the FSK modem command interpreter.
`default_nettype none
package fmci_pkg;

    typedef enum logic [1:0] {
        ST_WAIT   = 2'b00,
        ST_XCHG   = 2'b01,
        ST_DECODE = 2'b10,
        ST_TASK   = 2'b11
    } fmci_state_t;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] arg;
    } fmci_cmd_t;

    typedef struct packed {
        logic [1:0] speed;
        logic       bell;
        logic       call_role;
        logic       loopback;
        logic [1:0] tx_mode;
        logic [1:0] tone_sel;
        logic [1:0] rx_mode;
        logic       fsk_enable;
    } fmci_mode_t;

endpackage : fmci_pkg
`default_nettype wire

/* File: tb/fmci_ctrl_model.sv */
// Behavioural model of the controller that issues setup commands.
`timescale 1ns/10ps
`default_nettype none
module fmci_ctrl_model (
    input  wire logic       clk_i,
    input  wire logic       ready_i,
    output logic            valid_o,
    output logic [7:0]      word_o
);
    // ------------------------------------------------------------
    // Command issue
    // ------------------------------------------------------------
    // A taken word is replaced by its inverse, so late sampling fails.
    initial
    begin
        valid_o = 1'b0;
        word_o  = 8'h00;
    end

    task automatic send(input logic [7:0] w, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        #1;
        valid_o = 1'b1;
        word_o  = w;
        @(posedge clk_i);
        while (ready_i !== 1'b1 && n < 2000)
        begin
            n++;
            @(posedge clk_i);
        end
        ok = (n < 2000);
        #1;
        valid_o = 1'b0;
        word_o  = ~w;
    endtask : send
endmodule : fmci_ctrl_model
`default_nettype wire

/* File: tb/fsk_modem_command_interpreter_tb.sv */
// Self-checking testbench of the FSK modem command interpreter.
`timescale 1ns/10ps
`default_nettype none
module fsk_modem_command_interpreter_tb
    import fmci_pkg::*;
;
    typedef struct packed {
        fmci_cmd_t  cmd;
        fmci_mode_t mode;
    } fmci_note_t;
    logic       clk_i, reset_i, frame_flag_i, agc_dis, inband_energy_detect, rx_bit;
    logic [7:0] cmd_word, status, codec_in, codec_out, tx_smp, rx_smp;
    logic       cmd_valid, cmd_ready, strobe, role, loopb, bell, fsk;
    logic       tone_flag, dec_step, gain_upd;
    logic [1:0] speed, tx_mode, tone_sel, rx_mode;
    logic [3:0] digit;
    logic [4:0] cnt;
    fmci_mode_t got_mode, exp_mode;
    fmci_note_t notes[$];
    fmci_note_t cur = 20'h00100; // Reset modes hold only the answer role.
    int         n_mismatch = 0;
    int         n_strobe = 0;
    int         n_gain = 0;
    int         samples_checked = 0;
    assign got_mode = {speed, bell, role, loopb, tx_mode, tone_sel,
                       rx_mode, fsk};

    fmci_top dut (.clk_i(clk_i), .reset_i(reset_i),
        .received_command_word_i(cmd_word), .command_valid_i(cmd_valid),
        .command_ready_o(cmd_ready), .returned_status_word_o(status),
        .frame_flag_i(frame_flag_i), .codec_in_sample_i(codec_in),
        .codec_out_sample_o(codec_out), .tx_sample_i(tx_smp),
        .rx_sample_o(rx_smp), .sample_strobe_o(strobe),
        .agc_disable_i(agc_dis), .inband_energy_detect_i(inband_energy_detect),
        .rx_data_bit_i(rx_bit), .speed_o(speed), .bell_mode_o(bell),
        .call_role_flag_o(role), .loopback_o(loopb), .tx_mode_o(tx_mode),
        .tone_sel_o(tone_sel), .rx_mode_o(rx_mode), .fsk_enable_o(fsk),
        .tone_dialling_flag_o(tone_flag), .dtmf_digit_o(digit),
        .command_decode_step_o(dec_step),
        .gain_control_update_o(gain_upd), .tx_sample_counter_o(cnt));
    fmci_ctrl_model ctl (.clk_i(clk_i), .ready_i(cmd_ready),
        .valid_o(cmd_valid), .word_o(cmd_word));

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : stop_test

    task automatic chk_bits(input logic [7:0] g, e, input string what);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, g, e);
        end
    endtask : chk_bits

    task automatic chk_mode(input fmci_mode_t g, e);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch at %0t: modes got %h exp %h", $time, g, e);
        end
    endtask : chk_mode

    function automatic fmci_mode_t next_mode(fmci_mode_t m, fmci_cmd_t c);
        case (c.op)
            4'hF: {m.call_role, m.bell, m.speed} = {~c.arg[3], c.arg[2:0]};
            4'hD: if (c.arg[1] == 1'b0) m.loopback = c.arg[0];
            4'h8:
            begin
                if (c.arg[1:0] != 2'h3) m.tx_mode = c.arg[1:0];
                if (c.arg[3:2] != 2'h3) m.tone_sel = c.arg[3:2];
            end
            4'h7: if (c.arg[0] == 1'b0) m.rx_mode = c.arg[1:0];
            4'h5: m.fsk_enable = c.arg[0];
            default: m = m;
        endcase
        return m;
    endfunction : next_mode

    task automatic put(input fmci_cmd_t c);
        logic ok;
        ctl.send(c, ok);
        if (!ok) chk_bits(8'h00, 8'h01, "command never taken");
        exp_mode = next_mode(exp_mode, c);
        notes.push_back('{c, exp_mode});
    endtask : put

    // ------------------------------------------------------------
    // Clock, watchdog, monitor and codec frames
    // ------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial
    begin
        #(8 * 60000);
        n_mismatch++;
        $display("mismatch at %0t: run did not finish", $time);
        stop_test();
    end

    always @(negedge clk_i)
    begin
        if (strobe === 1'b1)
            n_strobe++;
        if (gain_upd === 1'b1)
            n_gain++;
        if (dec_step === 1'b1 && notes.size() > 0)
        begin
            cur = notes.pop_front();
            chk_bits({3'h0, cnt}, 8'h1F, "decode slot");
            chk_mode(got_mode,
                     cur.mode);
            if (cur.cmd.op == 4'h9)
                chk_bits({3'h0, tone_flag, digit}, {4'h1, cur.cmd.arg},
                         "dial");
        end
        if (gain_upd === 1'b1)
            chk_bits({2'h0, tone_flag, cnt}, 8'h1F,
                     "gain slot");
    end

    initial
    begin : frames
        logic [4:0] prev;
        int         s0;
        int         g0;
        frame_flag_i = 1'b0;
        {codec_in, tx_smp, agc_dis, inband_energy_detect, rx_bit} = 19'h00000;
        wait (reset_i === 1'b0);
        repeat (4) @(posedge clk_i);
        forever
        begin
            @(posedge clk_i);
            #1;
            prev = cnt;
            s0 = n_strobe;
            g0 = n_gain;
            frame_flag_i = 1'b1;
            {codec_in, tx_smp} = 16'($urandom);
            {agc_dis, inband_energy_detect, rx_bit} = 3'($urandom);
            repeat (3) @(posedge clk_i);
            #1;
            frame_flag_i = 1'b0;
            repeat (8) @(posedge clk_i);
            #1;
            chk_bits({3'h0, cnt}, {3'h0, prev == 5'h00 ? 5'h1F : prev - 5'h01},
                     "count");
            chk_bits(8'(n_strobe - s0), 8'h01, "strobe");
            chk_bits(8'(n_gain - g0), {7'h0, prev == 5'h00},
                     "gain pulse");
            chk_bits(status, {agc_dis, inband_energy_detect, 2'h0, rx_bit, 3'h7},
                     "status");
            chk_bits(rx_smp, codec_in, "rx sample");
            if (cnt != 5'h1E)
                chk_bits(codec_out, cur.mode.tx_mode == 2'h0 ? 8'h00 : tx_smp,
                         "tx sample");
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin : main
        logic [7:0] fixed [19];
        logic [3:0] ops [8];
        fixed = '{8'hF4, 8'hF9, 8'hD1, 8'hD2, 8'hD0, 8'h9B, 8'h9E, 8'h81,
                  8'h85, 8'h8A, 8'h8F, 8'h80, 8'h72, 8'h71, 8'h70, 8'h51,
                  8'h5E, 8'h46, 8'hE3};
        ops = '{4'hF, 4'hD, 4'h9, 4'h8, 4'h7, 4'h5, 4'hE, 4'h3};
        reset_i = 1'b1;
        exp_mode = '0;
        exp_mode.call_role = 1'b1;
        void'($urandom(77372));
        repeat (6) @(posedge clk_i);
        #1;
        chk_bits(status, 8'h81, "reset status");
        chk_bits({2'h0, cnt, role}, 8'h3F, "reset count");
        chk_bits({7'h0, cmd_ready}, 8'h00, "ready in reset");
        reset_i = 1'b0;
        foreach (fixed[i])
            put(fixed[i]);
        repeat (12)
            put({ops[$urandom % 8], 4'($urandom)});
        for (int i = 0; i < 40000 && notes.size() > 0; i++)
            @(posedge clk_i);
        // Fill the command buffer with ignored words while none are drained.
        for (int i = 0; i < 32; i++)
            put(8'h20 + 8'(i % 16));
        @(posedge clk_i);
        #1;
        chk_bits({7'h0, cmd_ready}, 8'h00, "buffer full");
        put(8'h6A);
        for (int i = 0; i < 40000 && notes.size() > 0; i++)
            @(posedge clk_i);
        chk_bits(8'(notes.size()), 8'h00, "undecoded");
        stop_test();
    end
endmodule : fsk_modem_command_interpreter_tb
`default_nettype wire
